// ---- hw/pin_mode_consts.svh ----
// register offsets, field positions, reset values and timing figures
// of the multifunction pin mode block.
// included by bare name; holds definitions only.
`ifndef PIN_MODE_CONSTS_SVH
`define PIN_MODE_CONSTS_SVH

`define PM_ADDR_W         8
`define PM_DATA_W         8
`define PM_CFG_OFFSET     8'h0e
`define PM_STATUS_OFFSET  8'h40
`define PM_CFG_RESET      8'h00
`define PM_RDATA_RESET    8'h00

`define PM_FIRST_MODE_MSB 7
`define PM_FIRST_MODE_LSB 5
`define PM_SECOND_MODE_MSB 4
`define PM_SECOND_MODE_LSB 2
`define PM_DEB_SEL_MSB    1
`define PM_DEB_SEL_LSB    0

`define PM_CORE_CLK_HZ    50000000
`define PM_DEB_LONG_MS    160
`define PM_DEB_MID_MS     80
`define PM_DEB_SHORT_MS   40
`define PM_MS_CYCLES      (`PM_CORE_CLK_HZ / 1000)
`define PM_DEB_CNT_W      23

`define PM_SYNC_STAGES    3
`define PM_ASYNC_INPUTS   5

`endif

// ---- hw/pin_mode_pkg.sv ----
// types shared by the multifunction pin mode block.
// assumes nothing of its surroundings.
package pin_mode_pkg;

   typedef enum logic [2:0] {
      MODE_PG_LOW  = 3'h0,
      MODE_PG_HIGH = 3'h1,
      MODE_POS_OV  = 3'h2,
      MODE_POS_UV  = 3'h3,
      MODE_NEG_OV  = 3'h4,
      MODE_NEG_UV  = 3'h5,
      MODE_FLAG    = 3'h6,
      MODE_OFF     = 3'h7
   } pin_mode_type;

   typedef enum logic [1:0] {
      DEB_MID   = 2'h0,
      DEB_NONE  = 2'h1,
      DEB_SHORT = 2'h2,
      DEB_LONG  = 2'h3
   } debounce_sel_type;

   typedef struct packed {
      pin_mode_type     first_pin_mode_select;
      pin_mode_type     second_pin_mode_select;
      debounce_sel_type on_request_debounce_select;
   } config_type;

   typedef struct packed {
      logic flag;
      logic overvoltage_indication;
      logic undervoltage_indication;
   } pin_status_type;

endpackage

// ---- hw/supply_on_debounce.sv ----
// debounce filter for the synchronised supply-on request.
// assumes sample_i is already on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mode_consts.svh"

module supply_on_debounce #(
   parameter int unsigned LONG_CYC  = 8000000,
   parameter int unsigned MID_CYC   = 4000000,
   parameter int unsigned SHORT_CYC = 2000000
) (
   input  wire logic                          core_clk_i,
   input  wire logic                          nrst_i,
   input  wire logic                          sample_i,
   input  wire pin_mode_pkg::debounce_sel_type sel_i,
   output logic                               debounced_o
);
   import pin_mode_pkg::*;

   logic [`PM_DEB_CNT_W-1:0] count;
   logic [`PM_DEB_CNT_W-1:0] limit;
   wire                      differs = sample_i != debounced_o;
   wire                      bypass  = sel_i == DEB_NONE;
   wire                      expired = count >= limit;

   // count of stable cycles needed minus one
   always_comb begin
      case (sel_i)
         DEB_MID:   limit = `PM_DEB_CNT_W'(MID_CYC - 1);
         DEB_SHORT: limit = `PM_DEB_CNT_W'(SHORT_CYC - 1);
         DEB_LONG:  limit = `PM_DEB_CNT_W'(LONG_CYC - 1);
         default:   limit = '0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count       <= '0;
         debounced_o <= 1'b0;
      end else if (!differs) begin
         count <= '0;
      end else if (bypass || expired) begin
         count       <= '0;
         debounced_o <= sample_i;
      end else begin
         count <= count + 1'b1;
      end
   end

endmodule
`default_nettype wire

// ---- hw/multifunction_pin_mode_config.sv ----
// multifunction pin mode configuration: two pins that are either
// power-good outputs or comparator-fed flags, plus supply-on debounce.
// assumes analog comparators and the supply-on pin are asynchronous,
// and that the eeprom default and power-good sources share core_clk_i.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mode_consts.svh"

// Operation
// - after power-up the config register takes the eeprom default value
// - first pin modes 000 and 001 drive the dc power-good output
// - first pin 010: below lower clears flag and ov, above sets both
// - first pin 011: below asserts uv flag clear, above sets flag
// - first pin 100: below asserts ov flag clear, above sets flag
// - first pin 101: below clears all, above sets flag and uv
// - first pin 110: flag follows input, ov and uv stay low
// - first pin 111: flag, ov and uv all held low
// - second pin modes 000 and 001 give the ac power-good function
// - second pin positive modes compare against the dac level
// - second pin negative modes compare against the dac level
// - second pin 110: flag follows the dac comparison, ov uv low
// - debounce code picks 80, 40 or 160 ms, or no filtering, for the supply-on request
module multifunction_pin_mode_config #(
   parameter int unsigned DEB_LONG_CYC  = `PM_DEB_LONG_MS * `PM_MS_CYCLES,
   parameter int unsigned DEB_MID_CYC   = `PM_DEB_MID_MS * `PM_MS_CYCLES,
   parameter int unsigned DEB_SHORT_CYC = `PM_DEB_SHORT_MS * `PM_MS_CYCLES
) (
   input  wire logic                  core_clk_i,
   input  wire logic                  nrst_i,
   input  wire logic [`PM_ADDR_W-1:0] addr_i,
   input  wire logic [`PM_DATA_W-1:0] wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output logic      [`PM_DATA_W-1:0] rdata_o,
   input  wire logic [`PM_DATA_W-1:0] eeprom_default_i,
   input  wire logic                  dc_good_i,
   input  wire logic                  ac_good_i,
   input  wire logic                  first_above_1v15_i,
   input  wire logic                  first_above_1v25_i,
   input  wire logic                  first_above_1v35_i,
   input  wire logic                  second_above_dac_i,
   input  wire logic                  supply_on_request_i,
   output logic                       dc_power_good_output_o,
   output logic                       dc_power_good_oe_o,
   output logic                       ac_power_good_o,
   output logic                       ac_power_good_active_o,
   output logic                       first_pin_flag_o,
   output logic                       first_overvoltage_o,
   output logic                       first_undervoltage_o,
   output logic                       second_pin_flag_o,
   output logic                       second_overvoltage_o,
   output logic                       second_undervoltage_o,
   output logic                       supply_on_request_o
);
   import pin_mode_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // status decode shared by both pins

   function automatic pin_status_type decode(
      input pin_mode_type mode,
      input logic         high
   );
      pin_status_type s;
      s = '0;
      case (mode)
         MODE_POS_OV: begin
            s.flag                   = high;
            s.overvoltage_indication = high;
         end
         MODE_POS_UV: begin
            s.flag                    = high;
            s.undervoltage_indication = !high;
         end
         MODE_NEG_OV: begin
            s.flag                   = high;
            s.overvoltage_indication = !high;
         end
         MODE_NEG_UV: begin
            s.flag                    = high;
            s.undervoltage_indication = high;
         end
         MODE_FLAG: begin
            s.flag = high;
         end
         default: begin
            s = '0;
         end
      endcase
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // configuration register and power-up load

   config_type cfg;
   logic       loaded;

   wire cfg_sel    = addr_i == `PM_CFG_OFFSET;
   wire status_sel = addr_i == `PM_STATUS_OFFSET;
   wire cfg_write  = wr_i && cfg_sel;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg    <= config_type'(`PM_CFG_RESET);
         loaded <= 1'b0;
      end else if (!loaded) begin
         // eeprom shadow caught at the first edge after release
         cfg    <= config_type'(eeprom_default_i);
         loaded <= 1'b1;
      end else if (cfg_write) begin
         cfg <= config_type'(wdata_i);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // three-stage synchronisers for asynchronous inputs

   logic [`PM_ASYNC_INPUTS-1:0] raw;
   logic [`PM_ASYNC_INPUTS-1:0] sync1;
   logic [`PM_ASYNC_INPUTS-1:0] sync2;
   logic [`PM_ASYNC_INPUTS-1:0] sync3;
   logic [`PM_ASYNC_INPUTS-1:0] clean;

   assign raw = {supply_on_request_i,
                 second_above_dac_i,
                 first_above_1v35_i,
                 first_above_1v25_i,
                 first_above_1v15_i};

   genvar gi;
   generate
      for (gi = 0; gi < `PM_ASYNC_INPUTS; gi++) begin : g_sync
         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
               clean[gi] <= 1'b0;
            end else begin
               sync1[gi] <= raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               // a change counts once stages two and three agree
               if (sync2[gi] == sync3[gi]) begin
                  clean[gi] <= sync3[gi];
               end
            end
         end
      end
   endgenerate

   wire above_1v15 = clean[0];
   wire above_1v25 = clean[1];
   wire above_1v35 = clean[2];
   wire above_dac  = clean[3];
   wire on_request = clean[4];

   ////////////////////////////////////////////////////////////////////
   // first pin: threshold pair chosen by mode, hysteresis state

   pin_mode_type first_mode;
   pin_mode_type second_mode;
   logic         first_high;
   logic         next_first_high;
   logic         second_high;

   assign first_mode  = cfg.first_pin_mode_select;
   assign second_mode = cfg.second_pin_mode_select;

   // uv-positive and ov-negative use the 1.25 / 1.35 V pair
   wire upper_pair = (first_mode == MODE_POS_UV) ||
                     (first_mode == MODE_NEG_OV);
   wire over_upper = upper_pair ? above_1v35 : above_1v25;
   wire over_lower = upper_pair ? above_1v25 : above_1v15;

   // between the thresholds the previous state is kept
   assign next_first_high = over_upper ? 1'b1 :
                            !over_lower ? 1'b0 : first_high;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         first_high  <= 1'b0;
         second_high <= 1'b0;
      end else begin
         first_high  <= next_first_high;
         second_high <= above_dac;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin functions and flag outputs

   pin_status_type first_status;
   pin_status_type second_status;

   wire first_is_pg  = (first_mode == MODE_PG_LOW) ||
                       (first_mode == MODE_PG_HIGH);
   wire second_is_pg = (second_mode == MODE_PG_LOW) ||
                       (second_mode == MODE_PG_HIGH);

   assign first_status  = decode(first_mode, first_high);
   assign second_status = decode(second_mode, second_high);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dc_power_good_output_o <= 1'b0;
         dc_power_good_oe_o     <= 1'b0;
         ac_power_good_o        <= 1'b0;
         ac_power_good_active_o <= 1'b0;
      end else begin
         dc_power_good_oe_o     <= first_is_pg;
         dc_power_good_output_o <= first_is_pg && dc_good_i;
         ac_power_good_active_o <= second_is_pg;
         ac_power_good_o        <= second_is_pg && ac_good_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         first_pin_flag_o      <= 1'b0;
         first_overvoltage_o   <= 1'b0;
         first_undervoltage_o  <= 1'b0;
         second_pin_flag_o     <= 1'b0;
         second_overvoltage_o  <= 1'b0;
         second_undervoltage_o <= 1'b0;
      end else begin
         first_pin_flag_o      <= first_status.flag;
         first_overvoltage_o   <= first_status.overvoltage_indication;
         first_undervoltage_o  <= first_status.undervoltage_indication;
         second_pin_flag_o     <= second_status.flag;
         second_overvoltage_o  <= second_status.overvoltage_indication;
         second_undervoltage_o <= second_status.undervoltage_indication;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // supply-on request debounce

   logic on_debounced;

   supply_on_debounce #(
      .LONG_CYC  (DEB_LONG_CYC),
      .MID_CYC   (DEB_MID_CYC),
      .SHORT_CYC (DEB_SHORT_CYC)
   ) u_debounce (
      .core_clk_i  (core_clk_i),
      .nrst_i      (nrst_i),
      .sample_i    (on_request),
      .sel_i       (cfg.on_request_debounce_select),
      .debounced_o (on_debounced)
   );

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         supply_on_request_o <= 1'b0;
      end else begin
         supply_on_request_o <= on_debounced;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register read port, data valid in the cycle after the strobe

   logic [`PM_DATA_W-1:0] status_word;
   logic [`PM_DATA_W-1:0] next_rdata;

   assign status_word = {loaded,
                         supply_on_request_o,
                         second_undervoltage_o,
                         second_overvoltage_o,
                         second_pin_flag_o,
                         first_undervoltage_o,
                         first_overvoltage_o,
                         first_pin_flag_o};

   assign next_rdata = !rd_i      ? `PM_RDATA_RESET :
                       cfg_sel    ? `PM_DATA_W'(cfg) :
                       status_sel ? status_word :
                                    `PM_RDATA_RESET;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= `PM_RDATA_RESET;
      end else begin
         rdata_o <= next_rdata;
      end
   end

endmodule
`default_nettype wire

// ---- test/pin_mode_checker.sv ----
// concurrent checks on the ports of the multifunction pin mode block.
// bound from the bench top file; sees the top module's ports only.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mode_consts.svh"

module pin_mode_checker (
   input wire logic                  core_clk_i,
   input wire logic                  nrst_i,
   input wire logic [`PM_ADDR_W-1:0] addr_i,
   input wire logic [`PM_DATA_W-1:0] wdata_i,
   input wire logic                  wr_i,
   input wire logic                  rd_i,
   input wire logic [`PM_DATA_W-1:0] rdata_o,
   input wire logic                  dc_good_i,
   input wire logic                  supply_on_request_i,
   input wire logic                  dc_power_good_output_o,
   input wire logic                  dc_power_good_oe_o,
   input wire logic                  ac_power_good_o,
   input wire logic                  ac_power_good_active_o,
   input wire logic                  first_pin_flag_o,
   input wire logic                  first_overvoltage_o,
   input wire logic                  first_undervoltage_o,
   input wire logic                  second_pin_flag_o,
   input wire logic                  second_overvoltage_o,
   input wire logic                  second_undervoltage_o,
   input wire logic                  supply_on_request_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   wire logic [5:0] flags = {second_undervoltage_o, second_overvoltage_o,
      second_pin_flag_o, first_undervoltage_o, first_overvoltage_o,
      first_pin_flag_o};
   ////////////////////////////////////////////////////////////////////////
   property p_cfg_wr;
      wr_i && addr_i == `PM_CFG_OFFSET ##1 rd_i && addr_i == `PM_CFG_OFFSET
      |=> rdata_o == $past(wdata_i, 2);
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("config readback");
   property p_unmapped;
      rd_i && addr_i != `PM_CFG_OFFSET && addr_i != `PM_STATUS_OFFSET
      |=> rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   property p_rd_idle;
      !$past(rd_i) |-> rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
   property p_dc_out;
      dc_power_good_output_o |-> dc_power_good_oe_o && $past(dc_good_i);
   endproperty
   a_dc_out: assert property (p_dc_out) else $error("dc output");
   property p_dc_flags;
      dc_power_good_oe_o |-> flags[2:0] == 3'h0;
   endproperty
   a_dc_flags: assert property (p_dc_flags) else $error("dc flags");
   property p_ac_out;
      ac_power_good_o |-> ac_power_good_active_o;
   endproperty
   a_ac_out: assert property (p_ac_out) else $error("ac output");
   property p_ac_flags;
      ac_power_good_active_o |-> flags[5:3] == 3'h0;
   endproperty
   a_ac_flags: assert property (p_ac_flags) else $error("ac flags");
   property p_excl;
      !(flags[1] && flags[2]) && !(flags[4] && flags[5]);
   endproperty
   a_excl: assert property (p_excl) else $error("ov and uv");
   property p_deb;
      $changed(supply_on_request_o)
      |-> supply_on_request_o == $past(supply_on_request_i, 4);
   endproperty
   a_deb: assert property (p_deb) else $error("debounce");
   property p_status;
      rd_i && addr_i == `PM_STATUS_OFFSET |=> rdata_o[5:0] == $past(flags)
      && rdata_o[6] == $past(supply_on_request_o);
   endproperty
   a_status: assert property (p_status) else $error("status read");
   c_dc: cover property (dc_power_good_oe_o && dc_power_good_output_o);
   c_uv: cover property (first_undervoltage_o && second_undervoltage_o);
   c_son: cover property ($rose(supply_on_request_o));
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the multifunction pin mode block.
// drives every port itself; the checker is bound at the foot.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mode_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end

module tb;
   import pin_mode_pkg::*;
   localparam int L_CYC = 40, M_CYC = 20, S_CYC = 10;
   localparam logic [2:0] LO [2:7] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h0};
   localparam logic [2:0] HI [2:7] = '{3'h6, 3'h4, 3'h4, 3'h5, 3'h4, 3'h0};
   logic       clk, nrst_i, wr_i, rd_i, dc_good_i, ac_good_i;
   logic [7:0] addr_i, wdata_i, eeprom_default_i;
   logic       a15, a25, a35, dac, son;
   wire logic [7:0] rdata;
   wire logic  dco, dcoe, aco, acact, f1, ov1, uv1, f2, ov2, uv2, son_o;
   int         errors = 0, check_count = 0, n;
   logic [1:0] dsel [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
   int         dn [4] = '{1, S_CYC, M_CYC, L_CYC};

   multifunction_pin_mode_config #(.DEB_LONG_CYC(L_CYC),
      .DEB_MID_CYC(M_CYC), .DEB_SHORT_CYC(S_CYC)) dut (
      .core_clk_i(clk), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
      .eeprom_default_i(eeprom_default_i), .dc_good_i(dc_good_i),
      .ac_good_i(ac_good_i), .first_above_1v15_i(a15),
      .first_above_1v25_i(a25), .first_above_1v35_i(a35),
      .second_above_dac_i(dac), .supply_on_request_i(son),
      .dc_power_good_output_o(dco), .dc_power_good_oe_o(dcoe),
      .ac_power_good_o(aco), .ac_power_good_active_o(acact),
      .first_pin_flag_o(f1), .first_overvoltage_o(ov1),
      .first_undervoltage_o(uv1), .second_pin_flag_o(f2),
      .second_overvoltage_o(ov2), .second_undervoltage_o(uv2),
      .supply_on_request_o(son_o));
   ////////////////////////////////////////////////////////////////////////
   task tick(input int c);
      repeat (c) @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge clk);
      wr_i <= 1'b0;
      // one idle edge so the next call never re-drives wr_i in this step
      @(posedge clk);
   endtask
   // compares after the answer edge, then realigns to the next edge
   task rd(input logic [7:0] a, input logic [7:0] e);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge clk);
      rd_i <= 1'b0;
      #1 `CHK(rdata, e)
      @(posedge clk);
   endtask
   task pins(input logic [3:0] v);
      {a15, a25, a35, dac} <= v;
   endtask
   task flags(input logic [2:0] e);
      `CHK({f1, ov1, uv1}, e)
      `CHK({f2, ov2, uv2}, e)
   endtask
   task conclude;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #400000 errors++;
      $display("watchdog expired");
      conclude;
   end
   initial begin
      nrst_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00;
      wdata_i = 8'h00; eeprom_default_i = 8'hd9; dc_good_i = 1'b0;
      ac_good_i = 1'b0; {a15, a25, a35, dac} = 4'h0; son = 1'b0;
      tick(2);
      nrst_i <= 1'b1;
      tick(2);
      rd(`PM_CFG_OFFSET, 8'hd9);
      wr(8'h33, 8'h00);
      wr(`PM_STATUS_OFFSET, 8'h00);
      rd(`PM_CFG_OFFSET, 8'hd9);
      rd(8'h33, 8'h00);
      $display("test eeprom_default done");
      for (int m = 2; m < 8; m++) begin
         wr(`PM_CFG_OFFSET, {m[2:0], m[2:0], 2'h1});
         rd(`PM_CFG_OFFSET, {m[2:0], m[2:0], 2'h1});
         pins(4'h0);
         tick(8);
         flags(LO[m]);
         pins(4'hf);
         tick(8);
         flags(HI[m]);
         pins((m == 3 || m == 4) ? 4'hd : 4'h9);
         tick(8);
         flags(HI[m]);
      end
      $display("test comparator_modes done");
      for (int m = 0; m < 2; m++) begin
         pins(4'hf); dc_good_i <= 1'b1; ac_good_i <= 1'b1;
         wr(`PM_CFG_OFFSET, {m[2:0], m[2:0], 2'h1});
         tick(3);
         `CHK({dco, dcoe, f1, ov1, uv1}, 5'h18)
         `CHK({aco, acact, f2, ov2, uv2}, 5'h18)
         dc_good_i <= 1'b0; ac_good_i <= 1'b0;
         tick(3);
         `CHK({dco, dcoe, aco, acact}, 4'h5)
      end
      rd(`PM_STATUS_OFFSET, 8'h80);
      $display("test power_good done");
      for (int i = 0; i < 4; i++) begin
         wr(`PM_CFG_OFFSET, {6'h3f, dsel[i]});
         tick(3);
         son <= 1'b1; n = 0;
         // look off the edge so the launching update has settled
         while (son_o !== 1'b1 && n < 100) begin
            tick(1);
            #1;
            n++;
         end
         `CHK(n >= dn[i] && n <= dn[i] + 8, 1'b1)
         son <= 1'b0;
         tick(dn[i] + 12);
         `CHK(son_o, 1'b0)
      end
      son <= 1'b1;
      tick(20);
      son <= 1'b0;
      tick(30);
      `CHK(son_o, 1'b0)
      $display("test debounce done");
      conclude;
   end
endmodule

bind multifunction_pin_mode_config pin_mode_checker chk (.*);
`default_nettype wire
